// *** tb_wakeup_and_aux_timers.sv ***
// Self-checking bench for the timer block
`timescale 1ns/1ns
`default_nettype none
module tb_wakeup_and_aux_timers
    import wat_pkg::*;
;
    logic        mclk, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        slow = 1'b0, tick = 1'b0, tx_end = 1'b0, card_present = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v, seed = 32'ha2fd801b;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] r, e;
    wat_out_t    sys_out;
    int          fail_count = 0, checked = 0, cyc = 0, div;
    int          n_req = 0, n_trim = 0, n_pd = 0, e_req = 0, e_trim = 0, e_pd = 0;

    // Ticks feed both the fast source and timer0 so clock selects share one driver
    wat_timers DUT (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .rready_unused_guard(1'b0),
        .s_axi_rready, .slow_oscillator_clock(slow), .aux_tick_fast(tick),
        .aux_tick_slow(1'b0), .timer0_underflow(tick), .timer1_underflow(1'b0),
        .tx_end, .rx_first_bits(1'b0), .card_present, .sys_out);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        chk(34'(got), 34'(exp));
    endtask

    // Write: both beats offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        @(posedge mclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge mclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
        rd(idx);
        chk({resp, rd_v}, {18'h0, exp});
    endtask

    // Slow clock stands still between bursts; tail covers the synchroniser
    task automatic slow_edges(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge mclk);
            slow <= 1'b1;
            repeat (4) @(posedge mclk);
            slow <= 1'b0;
        end
        repeat (6) @(posedge mclk);
    endtask

    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            tick <= 1'b1;
            @(posedge mclk);
            tick <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask

    task automatic final_report();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Pulse counters and hang ceiling
    always @(posedge mclk)
    begin
        cyc++;
        n_req += int'(sys_out.wake_request);
        n_trim += int'(sys_out.trim_done);
        n_pd += int'(sys_out.power_down_request);
        if (cyc == 30000)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(8'h23, 16'h0000);
        r = 16'(rnd()) | 16'h0100;
        wr(8'h1e, 16'h0012);
        wr(8'h1f, {8'h00, r[15:8]});
        wr(8'h20, {8'h00, r[7:0]});
        rdc(8'h1e, 16'h0012);
        rdc(8'h1f, {8'h00, r[15:8]});
        @(posedge mclk);
        tx_end <= 1'b1;
        @(posedge mclk);
        tx_end <= 1'b0;
        rdc(8'h21, {8'h00, r[15:8]});
        wr(8'h1f, {8'h00, ~r[15:8]});
        div = int'(rnd() % 8) + 1;
        pulse(div);
        e = r - 16'(div);
        rdc(8'h21, {8'h00, e[15:8]});
        wr(8'h22, 16'h0000);
        rdc(8'h22, {8'h00, e[7:0]});
        rd(8'h3f);
        chk({resp, rd_v}, {2'b10, 32'h0});
        wr(8'h3f, 16'h00ff);
        chk({resp, 32'h0}, {2'b10, 32'h0});
        wr(8'h30, 16'h0001);
        wr(8'h23, 16'h0080);
        rdc(8'h23, 16'h0000);
        // Each divider: no underflow one edge short, then a stop at zero
        for (int c = 0; c < 4; c++)
        begin
            div = (c == 0) ? 1 : 4 << c;
            wr(8'h32, 16'h0001);
            wr(8'h23, 16'(32'h00e4 + c));
            rdc(8'h23, 16'(32'h00a4 + c));
            slow_edges(div - 1);
            rdc(8'h32, 16'h0000);
            slow_edges(1);
            e_req++;
            e_trim++;
            rdc(8'h32, 16'h0001);
            rdc(8'h23, 16'(32'h0024 + c));
        end
        // Aux as trim timer: starts on the next slow edge, stops on the one after
        wr(8'h33, 16'h0002);
        wr(8'h1e, 16'h0030);
        wr(8'h32, 16'h0001);
        wr(8'h23, 16'h00e4);
        slow_edges(1);
        e_req++;
        rdc(8'h32, 16'h0009);
        slow_edges(2);
        e_trim++;
        rdc(8'h32, 16'h0001);
        rdc(8'h21, {8'h00, ~r[15:8]});
        chk_n(n_req, e_req);
        chk_n(n_trim, e_trim);
        wr(8'h1f, 16'h0000);
        wr(8'h20, 16'h0005);
        wr(8'h1e, 16'h0000);
        wr(8'h23, 16'h00dc);
        slow_edges(1);
        pulse(4);
        chk({33'h0, sys_out.rf_field_enable}, 34'h1);
        pulse(1);
        chk({33'h0, sys_out.rf_field_enable}, 34'h0);
        e_pd++;
        chk_n(n_pd, e_pd);
        rdc(8'h32, 16'h0001);
        rdc(8'h23, 16'h009c);
        card_present <= 1'b1;
        slow_edges(1);
        pulse(5);
        rdc(8'h32, 16'h0003);
        chk_n(n_pd, e_pd);
        chk({33'h0, sys_out.card_irq}, 34'h1);
        wr(8'h23, 16'h005c);
        rdc(8'h23, 16'h001c);
        final_report();
    end
endmodule
`default_nettype wire

// *** wat_checker.sv ***
// Port-level assertions for the timer block
`timescale 1ns/1ns
`default_nettype none
module wat_checker
    import wat_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        card_present,
    input wire wat_out_t    sys_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Bus answers one cycle after the take; no second address while busy
    AST_R_LATENCY: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_DONE: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    AST_AW_REFUSE: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write taken");
    AST_RDATA_HI: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    // Sticky flag only drops by a register write
    AST_IRQ_HOLD: assert property (
        $fell(sys_out.wake_irq) |-> $rose(s_axi_bvalid))
        else $error("wake flag lost");
    AST_REQ_IRQ: assert property (
        sys_out.wake_request |-> sys_out.wake_irq)
        else $error("wake without flag");
    // Card result taken as the field switches off
    AST_CARD_SAMPLE: assert property (
        $fell(sys_out.rf_field_enable) && $past(card_present) |-> sys_out.card_irq)
        else $error("card not flagged");
    AST_PD_AFTER_RF: assert property (
        sys_out.power_down_request |-> $past(sys_out.rf_field_enable, 2))
        else $error("power down out of place");
endmodule
bind wat_timers wat_checker u_chk (.mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_bvalid, .card_present, .sys_out);
`default_nettype wire

// *** wat_defines.svh ***
// Register indices, field positions, reset values and timing constants of the timers
`ifndef WAT_DEFINES_SVH
`define WAT_DEFINES_SVH

// Register indices; the AXI byte address is four times the index
`define WAT_IDX_AUX_CTRL      8'h1e
`define WAT_IDX_AUX_RELOAD_HI 8'h1f
`define WAT_IDX_AUX_RELOAD_LO 8'h20
`define WAT_IDX_AUX_COUNT_HI  8'h21
`define WAT_IDX_AUX_COUNT_LO  8'h22
`define WAT_IDX_WAKE_CTRL     8'h23
`define WAT_IDX_WAKE_RELOAD   8'h30
`define WAT_IDX_WAKE_COUNT    8'h31
`define WAT_IDX_STATUS        8'h32
`define WAT_IDX_AUX_CMD       8'h33

// Auxiliary timer control fields
`define WAT_AUX_STOP_RX_BIT   7
`define WAT_AUX_START_MSB     5
`define WAT_AUX_START_LSB     4
`define WAT_AUX_RELOAD_BIT    3
`define WAT_AUX_CLK_MSB       1
`define WAT_AUX_CLK_LSB       0

// Wake-up timer control fields
`define WAT_WAKE_RUN_BIT      7
`define WAT_WAKE_QUAL_BIT     6
`define WAT_WAKE_TRIM_BIT     5
`define WAT_WAKE_CD_BIT       4
`define WAT_WAKE_RELOAD_BIT   3
`define WAT_WAKE_RESUME_BIT   2
`define WAT_WAKE_CLK_MSB      1
`define WAT_WAKE_CLK_LSB      0

// Status and command fields
`define WAT_STAT_WAKE_IRQ_BIT 0
`define WAT_STAT_CARD_BIT     1
`define WAT_STAT_CD_BUSY_BIT  2
`define WAT_STAT_TRIM_BIT     3
`define WAT_CMD_START_BIT     0
`define WAT_CMD_STOP_BIT      1

// Reset values
`define WAT_RST_CTRL          8'h00
`define WAT_RST_WORD          16'h0000

// Slow clock prescaler terminal counts (divide minus one)
`define WAT_DIV1_LAST         5'h00
`define WAT_DIV8_LAST         5'h07
`define WAT_DIV16_LAST        5'h0f
`define WAT_DIV32_LAST        5'h1f

// AXI responses
`define WAT_RESP_OKAY         2'b00
`define WAT_RESP_SLVERR       2'b10

`endif

// *** wat_pkg.sv ***
// Types shared by the wake-up and auxiliary timer block
package wat_pkg;

    typedef enum logic [1:0] {
        WAT_CD_IDLE  = 2'b00,
        WAT_CD_FIELD = 2'b01,
        WAT_CD_DONE  = 2'b11
    } wat_cd_state_t;

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_idx;
        logic        aw_ok;
        logic        w_got;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [15:0] rdata;
        logic [1:0]  rresp;
    } wat_axi_t;

    typedef struct packed {
        logic        stop_rx;
        logic [1:0]  start_mode;
        logic        auto_reload;
        logic [1:0]  clock_select;
        logic [15:0] reload;
        logic [15:0] count;
        logic        running;
    } wat_aux_t;

    typedef struct packed {
        logic        running;
        logic        auto_trim;
        logic        auto_cd;
        logic        auto_reload;
        logic        auto_resume;
        logic [1:0]  clock_select;
        logic [15:0] reload;
        logic [15:0] count;
        logic [4:0]  prescale;
    } wat_wake_t;

    typedef struct packed {
        logic rf_field_enable;
        logic wake_request;
        logic power_down_request;
        logic card_irq;
        logic wake_irq;
        logic trim_done;
        logic trim_active;
    } wat_out_t;

    typedef struct packed {
        wat_axi_t      axi;
        wat_aux_t      aux;
        wat_wake_t     wake;
        wat_cd_state_t cd;
        logic          card_seen;
        logic          osc_s1;
        logic          osc_s2;
        logic          osc_s3;
        wat_out_t      out;
    } wat_state_t;

endpackage

// *** wat_timers.sv ***
// Wake-up timer, auxiliary timer and card detection sequencer behind an AXI4-Lite slave
//
// Functional notes
// - Each start event loads the aux counter from reload high and low bytes.
// - Writing aux reload bytes leaves a running count alone until next start.
// - Current aux count reads as two read-only bytes, high then low.
// - Wake control bit 7 reads back whether the wake timer runs.
// - Writes change the running bit only when the same write sets bit 6.
// - Auto-trim bit 5 launches oscillator trimming on each wake underflow.
// - Auto card-detect bit 4 runs card detection on each wake underflow that finds the sequencer idle.
// - Card found raises an interrupt request and the chip stays active.
// - No card found enters power-down when that is enabled.
// - The wake timer reloads at the underflow that launches card detection and keeps counting with no gap.
// - RF field stays on for the aux timer duration during detection.
// - Auto-reload bit 3 or auto card-detect bit 4 reloads wake timer at zero, else it stops.
// - Every wake timer underflow sets the wake interrupt flag.
// - Auto-resume bit 2 wakes the chip on wake timer underflow.
// - Wake clock select divides slow clock by 1, 8, 16 or 32.
`include "wat_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module wat_timers
    import wat_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              rready_unused_guard,
    input  wire logic              s_axi_rready,
    input  wire logic              slow_oscillator_clock,
    input  wire logic              aux_tick_fast,
    input  wire logic              aux_tick_slow,
    input  wire logic              timer0_underflow,
    input  wire logic              timer1_underflow,
    input  wire logic              tx_end,
    input  wire logic              rx_first_bits,
    input  wire logic              card_present,
    output wat_out_t               sys_out
);

    wat_state_t st;
    wat_state_t next_st;

    // Outputs come straight from the state flops
    assign s_axi_awready = st.axi.awready;
    assign s_axi_wready  = st.axi.wready;
    assign s_axi_bresp   = st.axi.bresp;
    assign s_axi_bvalid  = st.axi.bvalid;
    assign s_axi_arready = st.axi.arready;
    assign s_axi_rdata   = {16'h0000, st.axi.rdata};
    assign s_axi_rresp   = st.axi.rresp;
    assign s_axi_rvalid  = st.axi.rvalid;
    assign sys_out       = st.out;

    // Decode of a byte address into a register index; misaligned is unmapped
    function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        idx_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0) &&
                 ((i >= `WAT_IDX_AUX_CTRL && i <= `WAT_IDX_WAKE_CTRL) ||
                  (i >= `WAT_IDX_WAKE_RELOAD && i <= `WAT_IDX_AUX_CMD));
    endfunction

    // Next state of everything
    always_comb
    begin
        logic [7:0]  ridx;
        logic [7:0]  wb;
        logic [15:0] rval;
        logic [4:0]  div_last;
        logic        do_wr, osc_rise, wake_tick, wake_uf, aux_tick, aux_uf;
        logic        aux_start, aux_stop, trim_mode, cd_launch;

        next_st = st;
        ridx    = s_axi_araddr[9:2];
        rval    = 16'h0000;
        do_wr   = 1'b0;
        wb      = st.axi.wdata[7:0];
        aux_start = 1'b0;
        aux_stop  = 1'b0;
        cd_launch = 1'b0;
        osc_rise  = 1'b0;
        div_last  = `WAT_DIV1_LAST;
        wake_tick = 1'b0;
        wake_uf   = 1'b0;
        aux_tick  = 1'b0;
        aux_uf    = 1'b0;
        trim_mode = 1'b0;

        // Pulses last one cycle
        next_st.out.wake_request       = 1'b0;
        next_st.out.power_down_request = 1'b0;
        next_st.out.trim_done          = 1'b0;

        // Slow oscillator synchroniser; edge detect looks only at later stages
        next_st.osc_s1 = slow_oscillator_clock;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_s3 = st.osc_s2;
        osc_rise       = st.osc_s2 & ~st.osc_s3;

        // AXI write channels, taken in either order
        if (st.axi.awready && s_axi_awvalid)
        begin
            next_st.axi.aw_got = 1'b1;
            next_st.axi.aw_idx = s_axi_awaddr[9:2];
            next_st.axi.aw_ok  = idx_ok(s_axi_awaddr);
        end
        if (st.axi.wready && s_axi_wvalid)
        begin
            next_st.axi.w_got = 1'b1;
            next_st.axi.wdata = s_axi_wdata[15:0];
            next_st.axi.wstrb = s_axi_wstrb[1:0];
        end
        if (st.axi.aw_got && st.axi.w_got && !st.axi.bvalid)
        begin
            do_wr              = st.axi.aw_ok;
            next_st.axi.bvalid = 1'b1;
            next_st.axi.bresp  = st.axi.aw_ok ? `WAT_RESP_OKAY : `WAT_RESP_SLVERR;
            next_st.axi.aw_got = 1'b0;
            next_st.axi.w_got  = 1'b0;
        end
        if (st.axi.bvalid && s_axi_bready)
            next_st.axi.bvalid = 1'b0;
        // Hold off new write beats until the response is gone
        next_st.axi.awready = !next_st.axi.aw_got && !next_st.axi.bvalid;
        next_st.axi.wready  = !next_st.axi.w_got && !next_st.axi.bvalid;

        // Read decode; count bytes are live, so a read during reception may tear
        case (ridx)
            `WAT_IDX_AUX_CTRL:
                rval[7:0] = {st.aux.stop_rx, 1'b0, st.aux.start_mode,
                             st.aux.auto_reload, 1'b0, st.aux.clock_select};
            `WAT_IDX_AUX_RELOAD_HI: rval[7:0] = st.aux.reload[15:8];
            `WAT_IDX_AUX_RELOAD_LO: rval[7:0] = st.aux.reload[7:0];
            `WAT_IDX_AUX_COUNT_HI:  rval[7:0] = st.aux.count[15:8];
            `WAT_IDX_AUX_COUNT_LO:  rval[7:0] = st.aux.count[7:0];
            `WAT_IDX_WAKE_CTRL:
                rval[7:0] = {st.wake.running, 1'b0, st.wake.auto_trim,
                             st.wake.auto_cd, st.wake.auto_reload,
                             st.wake.auto_resume, st.wake.clock_select};
            `WAT_IDX_WAKE_RELOAD:   rval = st.wake.reload;
            `WAT_IDX_WAKE_COUNT:    rval = st.wake.count;
            `WAT_IDX_STATUS:
                rval[7:0] = {4'h0, st.out.trim_active, (st.cd != WAT_CD_IDLE),
                             st.card_seen, st.out.wake_irq};
            default:                rval = 16'h0000;
        endcase
        if (st.axi.arready && s_axi_arvalid)
        begin
            next_st.axi.arready = 1'b0;
            next_st.axi.rvalid  = 1'b1;
            next_st.axi.rdata   = idx_ok(s_axi_araddr) ? rval : 16'h0000;
            next_st.axi.rresp   = idx_ok(s_axi_araddr) ? `WAT_RESP_OKAY : `WAT_RESP_SLVERR;
        end
        if (st.axi.rvalid && s_axi_rready)
        begin
            next_st.axi.rvalid  = 1'b0;
            next_st.axi.arready = 1'b1;
        end

        // Wake clock prescaler on slow oscillator edges
        case (st.wake.clock_select)
            2'b00:   div_last = `WAT_DIV1_LAST;
            2'b01:   div_last = `WAT_DIV8_LAST;
            2'b10:   div_last = `WAT_DIV16_LAST;
            default: div_last = `WAT_DIV32_LAST;
        endcase
        wake_tick = st.wake.running && osc_rise && (st.wake.prescale == div_last);
        if (st.wake.running && osc_rise)
            next_st.wake.prescale = wake_tick ? 5'h00 : st.wake.prescale + 5'h01;

        // Wake countdown; underflow is the step onto zero
        wake_uf = wake_tick && (st.wake.count <= 16'h0001);
        if (wake_tick)
            next_st.wake.count = st.wake.count - 16'h0001;
        if (wake_uf)
        begin
            next_st.out.wake_irq     = 1'b1;
            next_st.out.wake_request = st.wake.auto_resume;
            if (st.wake.auto_reload || st.wake.auto_cd)
            begin
                next_st.wake.count = st.wake.reload;
            end
            else
            begin
                next_st.wake.count   = 16'h0000;
                next_st.wake.running = 1'b0;
            end
            if (st.wake.auto_trim && !st.out.trim_active)
                next_st.out.trim_active = 1'b1;
            if (st.wake.auto_cd && st.cd == WAT_CD_IDLE)
                cd_launch = 1'b1;
        end

        // Aux input clock, as on the sibling timers
        case (st.aux.clock_select)
            2'b00:   aux_tick = aux_tick_fast;
            2'b01:   aux_tick = aux_tick_slow;
            2'b10:   aux_tick = timer0_underflow;
            default: aux_tick = timer1_underflow;
        endcase
        trim_mode = st.aux.start_mode[1];

        // Trim window: aux runs between two slow oscillator edges
        if (st.out.trim_active && osc_rise && trim_mode)
        begin
            if (!st.aux.running)
            begin
                aux_start = 1'b1;
            end
            else
            begin
                aux_stop                = 1'b1;
                next_st.out.trim_active = 1'b0;
                next_st.out.trim_done   = 1'b1;
            end
        end
        else if (st.out.trim_active && !trim_mode)
        begin
            // No trim timer set up here; the window belongs to another timer
            next_st.out.trim_active = 1'b0;
            next_st.out.trim_done   = 1'b1;
        end

        // Aux start and stop events
        if (st.aux.start_mode == 2'b01 && tx_end)
            aux_start = 1'b1;
        if (st.aux.stop_rx && rx_first_bits && !trim_mode)
            aux_stop = 1'b1;
        if (cd_launch)
            aux_start = 1'b1;

        // Aux countdown; start mode 2'b10 takes no underflow action and just parks at zero
        aux_uf = st.aux.running && aux_tick && (st.aux.count <= 16'h0001);
        if (st.aux.running && aux_tick && st.aux.count != 16'h0000)
            next_st.aux.count = st.aux.count - 16'h0001;
        if (aux_uf && st.aux.start_mode != 2'b10)
        begin
            if (st.aux.auto_reload && st.cd == WAT_CD_IDLE)
            begin
                next_st.aux.count = st.aux.reload;
            end
            else
            begin
                next_st.aux.count   = 16'h0000;
                next_st.aux.running = 1'b0;
            end
        end

        // Card detection sequencer
        case (st.cd)
            WAT_CD_IDLE:
            begin
                if (cd_launch)
                begin
                    next_st.cd                  = WAT_CD_FIELD;
                    next_st.out.rf_field_enable = 1'b1;
                end
            end
            WAT_CD_FIELD:
            begin
                // Field stays on until the aux window runs out
                if (aux_uf || !st.aux.running)
                begin
                    next_st.cd                  = WAT_CD_DONE;
                    next_st.out.rf_field_enable = 1'b0;
                    next_st.card_seen           = st.card_seen | card_present;
                    next_st.out.card_irq        = st.out.card_irq | card_present;
                end
            end
            WAT_CD_DONE:
            begin
                next_st.cd = WAT_CD_IDLE;
                if (!st.card_seen)
                begin
                    next_st.out.power_down_request = st.wake.auto_resume;
                end
            end
            default:
            begin
                next_st.cd                  = WAT_CD_IDLE;
                next_st.out.rf_field_enable = 1'b0;
            end
        endcase

        // Register writes; hardware sets above win over clears
        if (do_wr && st.axi.wstrb[0])
        begin
            case (st.axi.aw_idx)
                `WAT_IDX_AUX_CTRL:
                begin
                    next_st.aux.stop_rx      = wb[`WAT_AUX_STOP_RX_BIT];
                    next_st.aux.start_mode   = wb[`WAT_AUX_START_MSB:`WAT_AUX_START_LSB];
                    next_st.aux.auto_reload  = wb[`WAT_AUX_RELOAD_BIT];
                    next_st.aux.clock_select = wb[`WAT_AUX_CLK_MSB:`WAT_AUX_CLK_LSB];
                end
                `WAT_IDX_AUX_RELOAD_HI: next_st.aux.reload[15:8] = wb;
                `WAT_IDX_AUX_RELOAD_LO: next_st.aux.reload[7:0]  = wb;
                `WAT_IDX_WAKE_CTRL:
                begin
                    next_st.wake.auto_trim    = wb[`WAT_WAKE_TRIM_BIT];
                    next_st.wake.auto_cd      = wb[`WAT_WAKE_CD_BIT];
                    next_st.wake.auto_reload  = wb[`WAT_WAKE_RELOAD_BIT];
                    next_st.wake.auto_resume  = wb[`WAT_WAKE_RESUME_BIT];
                    next_st.wake.clock_select = wb[`WAT_WAKE_CLK_MSB:`WAT_WAKE_CLK_LSB];
                    if (wb[`WAT_WAKE_QUAL_BIT])
                    begin
                        next_st.wake.running  = wb[`WAT_WAKE_RUN_BIT];
                        next_st.wake.prescale = 5'h00;
                        if (wb[`WAT_WAKE_RUN_BIT] && !st.wake.running)
                        begin
                            next_st.wake.count = st.wake.reload;
                        end
                    end
                end
                `WAT_IDX_WAKE_RELOAD: next_st.wake.reload[7:0] = wb;
                `WAT_IDX_STATUS:
                begin
                    // Write one to clear; wake flag kept if its event lands this cycle, card flag kept while the field is on
                    if (wb[`WAT_STAT_WAKE_IRQ_BIT] && !wake_uf)
                    begin
                        next_st.out.wake_irq = 1'b0;
                    end
                    if (wb[`WAT_STAT_CARD_BIT] && st.cd != WAT_CD_FIELD)
                    begin
                        next_st.card_seen    = 1'b0;
                        next_st.out.card_irq = 1'b0;
                    end
                end
                `WAT_IDX_AUX_CMD:
                begin
                    aux_start = aux_start | wb[`WAT_CMD_START_BIT];
                    aux_stop  = aux_stop | wb[`WAT_CMD_STOP_BIT];
                end
                default: ;
            endcase
        end
        if (do_wr && st.axi.wstrb[1] && st.axi.aw_idx == `WAT_IDX_WAKE_RELOAD)
            next_st.wake.reload[15:8] = st.axi.wdata[15:8];

        // Start event loads the full reload word; stop wins over start
        if (aux_start && !aux_stop)
        begin
            next_st.aux.count   = st.aux.reload;
            next_st.aux.running = 1'b1;
        end
        else if (aux_stop)
            next_st.aux.running = 1'b0;
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st             <= '0;
            st.axi.awready <= 1'b1;
            st.axi.wready  <= 1'b1;
            st.axi.arready <= 1'b1;
            st.cd          <= WAT_CD_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule
`default_nettype wire
